// ### hw/crs_pkg.sv
// Constants and carrier types for the receive status channel formatter.
// Assumes a 40 MHz system clock and a 2048 kbit/s serial status stream.
package crs_pkg;
  // Clock rate and the printed times in milliseconds
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned ERR_HOLD_MS = 128;
  localparam int unsigned CRC_SEC_MS  = 1000;
  localparam int unsigned CRC_HIGH_MS = 8;
  localparam int unsigned REF_TOUT_MS = 8;
  // Cycle counts derived from the times (all above 4096, so top parameters)
  localparam int unsigned ERR_HOLD_CYC = CLK_HZ / 1000 * ERR_HOLD_MS;
  localparam int unsigned CRC_SEC_CYC  = CLK_HZ / 1000 * CRC_SEC_MS;
  localparam int unsigned CRC_HIGH_CYC = CLK_HZ / 1000 * CRC_HIGH_MS;
  localparam int unsigned REF_TOUT_CYC = CLK_HZ / 1000 * REF_TOUT_MS;
  // Channel numbers of the five status bytes
  localparam logic [4:0] CH_NFAS = 5'h11;
  localparam logic [4:0] CH_STATUS1 = 5'h12;
  localparam logic [4:0] CH_PHASE   = 5'h13;
  localparam logic [4:0] CH_CRC     = 5'h14;
  localparam logic [4:0] CH_STATUS2 = 5'h15;
  localparam logic [2:0] NUM_BYTES = 3'h5;
  // Phase slot limits for the ninth phase bit
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [4:0] SLOT_FIRST = 5'h00;
  // Error threshold, fixed levels and reset values
  localparam logic [4:0] ERR_THRESH = 5'h10;
  localparam logic       IDLE_LEVEL = 1'b1;
  localparam logic       UNUSED_BIT = 1'b0;
  localparam logic [7:0] EMPTY_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [7:0] CRC_MAX    = 8'hFF;
  // Buffer shape
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;
  // Events and levels from the receive framer, same clock domain
  typedef struct packed {
    logic       frame_lock_lost;
    logic       multiframe_lock_lost;
    logic       fas_err;
    logic       slip;
    logic       rx_all_ones_alarm;
    logic       rx_slot16_all_ones_alarm;
    logic       crc_err;
    logic       crc_mf_lock;
    logic       rx_multiframe_pulse;
    logic       spare_bit_frame13;
    logic       spare_bit_frame15;
    logic       nfas_valid;
    logic [7:0] nfas_byte;
    logic       tx_8khz_timing_out;
  } crs_rx_evt_t;
endpackage

// ### hw/crs_status.sv
// Receive status channel formatter: builds channel 17 to 21 status bytes
// and shifts them onto the serial status stream through an 8-word FIFO.
// Assumes framer events arrive on clk_sys; bus clock, frame pulse and the
// external status pin are asynchronous pins.
`timescale 1ns/100ps

module crs_fifo
#(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];      // Storage words
  logic [AW:0]  wp;           // Write pointer with wrap bit
  logic [AW:0]  rp;           // Read pointer with wrap bit
  logic [AW:0]  next_wp;
  logic [AW:0]  next_rp;
  logic         full;
  logic         empty;

  // Full when pointers match apart from the wrap bit
  always_comb
  begin
    full      = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    empty     = (wp == rp);
    in_ready  = !full;
    out_valid = !empty;
    out_data  = mem[rp[AW-1:0]];
    next_wp   = (in_valid && !full) ? wp + 1'b1 : wp;
    next_rp   = (out_ready && !empty) ? rp + 1'b1 : rp;
  end

  // Pointers registered; memory written on accepted pushes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (in_valid && !full)
      mem[wp[AW-1:0]] <= in_data;
  end
endmodule

module crs_status
#(
  parameter int unsigned ERR_HOLD = crs_pkg::ERR_HOLD_CYC,
  parameter int unsigned CRC_SEC  = crs_pkg::CRC_SEC_CYC,
  parameter int unsigned CRC_HIGH = crs_pkg::CRC_HIGH_CYC,
  parameter int unsigned REF_TOUT = crs_pkg::REF_TOUT_CYC
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 bus_clk_pin,
  input  wire logic                 frame_pulse_n_pin,
  input  wire logic                 external_status_pin,
  input  wire logic                 maint_enable,
  input  wire crs_pkg::crs_rx_evt_t evt,
  output logic                      status_serial_output,
  output logic                      status_drive_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // True for a slot that belongs to this block
  function automatic logic own_slot(input logic [4:0] s);
    own_slot = (s >= crs_pkg::CH_NFAS) && (s <= crs_pkg::CH_STATUS2);
  endfunction

  // Pin synchronisers; stage one is read only by stage two
  logic [1:0] clk_sy, fp_sy, xs_sy;
  logic       clk_d;          // Delayed synced bus clock for edge
  logic       tick;           // One bit time of the serial stream
  logic       sof;            // First bit of a frame
  logic [7:0] cnt, next_cnt;  // Slot in [7:3], bit in [2:0]
  always_comb
  begin
    tick     = clk_sy[1] && !clk_d;
    sof      = tick && !fp_sy[1];
    next_cnt = sof ? 8'h00 : (tick ? cnt + 8'h01 : cnt);
  end

  // Status state
  logic [7:0]  nfas_q, next_nfas_q;     // Channel 17 copy
  logic        err_tgl, next_err_tgl;   // Alignment error toggle
  logic [4:0]  err_cnt, next_err_cnt;   // Errors since last toggle
  logic [25:0] err_hold, next_err_hold; // Holdoff left after a toggle
  logic        slip_tgl, next_slip_tgl;
  logic        xs_q, next_xs_q;         // External status sample
  logic [7:0]  crc_cnt, next_crc_cnt;
  logic [25:0] sec_cnt, next_sec_cnt;   // Position in one second
  logic        timer_bit, next_timer_bit;
  logic        si13_q, next_si13_q, si15_q, next_si15_q;
  logic        ref_q, next_ref_q;       // CRC reframe flag
  logic        ref_arm, next_ref_arm;
  logic [25:0] ref_cnt, next_ref_cnt;
  logic        fll_d;                   // Delayed frame lock lost
  logic        tx8k_d;                  // Delayed transmit 8 kHz timing
  logic [7:0]  phase_q, next_phase_q;
  logic        phase_msb, next_phase_msb;
  logic        sec_end;
  logic        tx8k_rise;

  always_comb
  begin
    sec_end        = (sec_cnt == 26'(CRC_SEC - 1));
    tx8k_rise      = evt.tx_8khz_timing_out && !tx8k_d;
    // Channel 17 refresh on each non-alignment frame
    next_nfas_q    = evt.nfas_valid ? evt.nfas_byte : nfas_q;
    // Error count; holdoff keeps toggles 128 ms apart
    next_err_tgl   = err_tgl;
    next_err_hold  = (err_hold != 26'h0) ? err_hold - 26'h1 : err_hold;
    next_err_cnt   = (evt.fas_err && err_cnt < crs_pkg::ERR_THRESH) ? err_cnt + 5'h01
                                                                    : err_cnt;
    if (err_cnt >= crs_pkg::ERR_THRESH && err_hold == 26'h0)
    begin
      next_err_tgl  = !err_tgl;
      next_err_cnt  = evt.fas_err ? 5'h01 : 5'h00;
      next_err_hold = 26'(ERR_HOLD - 1);
    end
    next_slip_tgl  = evt.slip ? !slip_tgl : slip_tgl;
    next_xs_q      = sof ? xs_sy[1] : xs_q;
    // CRC counter wraps; a new error beats the per-second clear
    next_crc_cnt   = crc_cnt;
    if (maint_enable && sec_end)
      next_crc_cnt = crs_pkg::BYTE_RST;
    if (evt.crc_err)
      next_crc_cnt = next_crc_cnt + 8'h01;
    // Second timer: flag high for the last 8 ms, falls at wrap
    next_sec_cnt   = sec_end ? 26'h0 : sec_cnt + 26'h1;
    next_timer_bit = (next_sec_cnt >= 26'(CRC_SEC - CRC_HIGH));
    next_si15_q    = evt.rx_multiframe_pulse ? evt.spare_bit_frame15 : si15_q;
    next_si13_q    = evt.rx_multiframe_pulse ? evt.spare_bit_frame13 : si13_q;
    // Reframe watchdog started when frame alignment returns
    next_ref_arm   = ref_arm;
    next_ref_cnt   = ref_cnt;
    next_ref_q     = ref_q;
    if (fll_d && !evt.frame_lock_lost)
    begin
      next_ref_arm = 1'b1;
      next_ref_cnt = 26'h0;
    end
    else if (ref_arm)
      next_ref_cnt = ref_cnt + 26'h1;
    if (evt.crc_mf_lock || evt.frame_lock_lost)
      next_ref_arm = 1'b0;
    if (ref_arm && !evt.crc_mf_lock && ref_cnt == 26'(REF_TOUT - 1))
    begin
      next_ref_q   = maint_enable;
      next_ref_arm = 1'b0;
    end
    if (!maint_enable || evt.crc_mf_lock)
      next_ref_q   = 1'b0;
    // Phase latched on the transmit timing rising edge
    next_phase_q   = tx8k_rise ? cnt : phase_q;
    next_phase_msb = phase_msb;
    if (tx8k_rise &&
        ((phase_q[7:3] == crs_pkg::SLOT_LAST && cnt[7:3] == crs_pkg::SLOT_FIRST) ||
         (phase_q[7:3] == crs_pkg::SLOT_FIRST && cnt[7:3] == crs_pkg::SLOT_LAST)))
      next_phase_msb = !phase_msb;
  end

  // Status registers; reset gives a quiet, unlocked picture
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      clk_sy <= '0; fp_sy <= '1; xs_sy <= '0; clk_d <= 1'b0;
      cnt <= 8'h00; nfas_q <= crs_pkg::BYTE_RST; err_tgl <= 1'b0;
      err_cnt <= 5'h00; err_hold <= 26'h0; slip_tgl <= 1'b0; xs_q <= 1'b0;
      crc_cnt <= crs_pkg::BYTE_RST; sec_cnt <= 26'h0; timer_bit <= 1'b0;
      si13_q <= 1'b0; si15_q <= 1'b0; ref_q <= 1'b0; ref_arm <= 1'b0;
      ref_cnt <= 26'h0; fll_d <= 1'b0; tx8k_d <= 1'b0;
      phase_q <= crs_pkg::BYTE_RST; phase_msb <= 1'b0;
    end
    else
    begin
      clk_sy <= {clk_sy[0], bus_clk_pin};
      fp_sy <= {fp_sy[0], frame_pulse_n_pin};
      xs_sy <= {xs_sy[0], external_status_pin};
      clk_d <= clk_sy[1]; cnt <= next_cnt; nfas_q <= next_nfas_q;
      err_tgl <= next_err_tgl; err_cnt <= next_err_cnt;
      err_hold <= next_err_hold; slip_tgl <= next_slip_tgl;
      xs_q <= next_xs_q; crc_cnt <= next_crc_cnt; sec_cnt <= next_sec_cnt;
      timer_bit <= next_timer_bit; si13_q <= next_si13_q;
      si15_q <= next_si15_q; ref_q <= next_ref_q; ref_arm <= next_ref_arm;
      ref_cnt <= next_ref_cnt; fll_d <= evt.frame_lock_lost;
      tx8k_d <= evt.tx_8khz_timing_out; phase_q <= next_phase_q;
      phase_msb <= next_phase_msb;
    end
  end

  // Loader pushes the five bytes at each frame start; stalls on full
  logic [2:0] ld_idx, next_ld_idx;
  logic       ld_busy, next_ld_busy;
  logic [7:0] ld_byte;
  logic       f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_out_data;
  always_comb
  begin
    case (ld_idx)
      3'h0: ld_byte = nfas_q;
      3'h1: ld_byte = {evt.frame_lock_lost,
                       evt.multiframe_lock_lost,
                       err_tgl, slip_tgl,
                       evt.rx_all_ones_alarm,
                       evt.rx_slot16_all_ones_alarm,
                       xs_q, crs_pkg::UNUSED_BIT};
      3'h2: ld_byte = phase_q;
      3'h3: ld_byte = crc_cnt;
      3'h4: ld_byte = {si15_q, si13_q, crs_pkg::UNUSED_BIT,
                       crs_pkg::UNUSED_BIT, timer_bit, ref_q,
                       !evt.crc_mf_lock, phase_msb};
      default: ld_byte = crs_pkg::EMPTY_BYTE;
    endcase
    next_ld_idx  = ld_idx;
    next_ld_busy = ld_busy;
    if (ld_busy && f_in_ready)
    begin
      next_ld_idx  = ld_idx + 3'h1;
      next_ld_busy = (ld_idx != crs_pkg::NUM_BYTES - 3'h1);
    end
    if (sof && !ld_busy)
    begin
      next_ld_idx  = 3'h0;
      next_ld_busy = 1'b1;
    end
  end

  crs_fifo #(.W(crs_pkg::FIFO_W), .D(crs_pkg::FIFO_D)) u_fifo
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (ld_byte),
    .in_valid  (ld_busy),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // Shifter: takes a byte at bit 0 of each owned slot, MSB first
  logic [7:0] sh, next_sh;
  logic       next_out, next_en;
  always_comb
  begin
    f_out_ready = tick && own_slot(next_cnt[7:3]) && next_cnt[2:0] == 3'h0;
    next_sh     = sh;
    next_out    = status_serial_output;
    next_en     = status_drive_en;
    if (tick)
    begin
      if (!own_slot(next_cnt[7:3]))
      begin
        next_out = crs_pkg::IDLE_LEVEL;
        next_en  = 1'b0;
      end
      else if (next_cnt[2:0] == 3'h0)
      begin
        // An empty buffer sends a fixed idle byte rather than stale data
        next_sh  = f_out_valid ? f_out_data : crs_pkg::EMPTY_BYTE;
        next_out = next_sh[7];
        next_en  = 1'b1;
      end
      else
      begin
        next_sh  = {sh[6:0], crs_pkg::IDLE_LEVEL};
        next_out = sh[6];
        next_en  = 1'b1;
      end
    end
  end

  // Loader and shifter registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ld_idx <= 3'h0; ld_busy <= 1'b0; sh <= crs_pkg::EMPTY_BYTE;
      status_serial_output <= crs_pkg::IDLE_LEVEL; status_drive_en <= 1'b0;
    end
    else
    begin
      ld_idx <= next_ld_idx; ld_busy <= next_ld_busy; sh <= next_sh;
      status_serial_output <= next_out; status_drive_en <= next_en;
    end
  end

  // Checks
  sequence s_pop;
    f_out_ready && f_out_valid;
  endsequence
  a_nfas_capture: assert property (evt.nfas_valid |=> nfas_q == $past(evt.nfas_byte))
    else $error("channel 17 byte not captured");
  a_err_threshold: assert property ($changed(err_tgl) |-> $past(err_cnt) >= 5'h10)
    else $error("error toggle below threshold");
  a_err_spacing: assert property ($changed(err_tgl) |=> !$changed(err_tgl) [*8])
    else $error("error toggle too soon");
  a_slip_toggle: assert property (evt.slip |=> slip_tgl != $past(slip_tgl))
    else $error("slip toggle missed");
  a_crc_wrap: assert property (crc_cnt == 8'hFF && evt.crc_err && !sec_end
                               |=> crc_cnt == 8'h00)
    else $error("crc count did not wrap");
  a_crc_clear: assert property (maint_enable && sec_end && !evt.crc_err
                                |=> crc_cnt == 8'h00)
    else $error("crc count not cleared");
  a_si_refresh: assert property (evt.rx_multiframe_pulse |=>
                                 si15_q == $past(evt.spare_bit_frame15) &&
                                 si13_q == $past(evt.spare_bit_frame13))
    else $error("spare bits not refreshed");
  a_timer_fall: assert property ($fell(timer_bit) |-> sec_cnt == 26'h0)
    else $error("timer fell off the second boundary");
  a_ref_clear: assert property (!maint_enable |=> !ref_q)
    else $error("reframe flag held without maintenance");
  a_phase_latch: assert property (tx8k_rise |=> phase_q == $past(cnt))
    else $error("phase not latched");
  a_serial_msb: assert property (s_pop |=>
                                 status_drive_en &&
                                 status_serial_output == $past(f_out_data[7]))
    else $error("status byte not sent msb first");
endmodule

// ### test/crs_ctrl_model.sv
// Backplane controller model: makes the bit clock and frame pulse and
// reads channels 17 to 21 of the serial status stream.
// Assumes the status block answers well inside each half bit time.
`timescale 1ns/100ps

module crs_ctrl_model
(
  output logic        bus_clk_pin,
  output logic        frame_pulse_n_pin,
  input  wire logic   status_serial_output,
  input  wire logic   status_drive_en,
  output int          bit_idx,
  output logic [39:0] rx_bytes,
  output logic        done_tgl,
  output int          bad_bits
);
  int frames;  // Frames seen; framing checks wait for the first one

  // Free-running 2048 kHz bus clock, which never stops on this bus
  initial
  begin
    bus_clk_pin = 1'b0;
    frame_pulse_n_pin = 1'b1;
    bit_idx = 240;
    rx_bytes = '0;
    done_tgl = 1'b0;
    bad_bits = 0;
    frames = 0;
    #3000;
    forever
    begin
      #244;
      bus_clk_pin = 1'b1;
      bit_idx = (bit_idx + 1) % 256;
      if (bit_idx == 0)
        frames++;
      #244;
      bus_clk_pin = 1'b0;
      // Pulse spans the rising edge that opens bit 0 of channel 0
      frame_pulse_n_pin = (bit_idx == 255) ? 1'b0 : 1'b1;
      // Sample mid-bit, where the output has long settled
      if (frames > 0)
      begin
        if (bit_idx >= 136 && bit_idx < 176)
        begin
          if (status_drive_en !== 1'b1)
            bad_bits++;
          rx_bytes = {rx_bytes[38:0], status_serial_output};
          if (bit_idx == 175)
            done_tgl = ~done_tgl;
        end
        else if (status_drive_en !== 1'b0 || status_serial_output !== 1'b1)
          bad_bits++;
      end
    end
  end
endmodule

// ### test/testbench.sv
// Self-checking bench for the receive status channel formatter.
// Assumes the controller model supplies bit clock, frame pulse and captures.
`timescale 1ns/100ps

module testbench;
  // Short counts so that one second spans a few frames
  localparam int unsigned ERR_HOLD = 200;
  localparam int unsigned CRC_SEC  = 17000;
  localparam int unsigned CRC_HIGH = 5000;
  localparam int unsigned REF_TOUT = 100;
  // Phase readings that walk the slot 31 and slot 0 wrap both ways
  localparam int CORNER_K [6] = '{83, 250, 5, 100, 2, 253};
  logic                 clk_sys;
  logic                 rst;
  logic                 external_status_pin;
  logic                 maint_enable;
  crs_pkg::crs_rx_evt_t evt;
  logic                 bus_clk_pin;
  logic                 frame_pulse_n_pin;
  logic                 status_serial_output;
  logic                 status_drive_en;
  int                   bit_idx;
  int                   bad_bits;
  logic [39:0]          rx_bytes;
  logic                 done_tgl;
  int                   err_count;
  int                   n_compared;
  int                   seed;
  int                   err_acc;   // Frame errors not yet turned into a toggle
  int                   highs;     // Snapshots that saw the second timer high
  logic                 err_tgl;
  logic                 slip_tgl;
  logic                 ref_flag;
  logic                 fll_prev;
  logic                 t_prev;
  logic [7:0]           crc_exp;
  logic [8:0]           word;      // Last latched phase with its ninth bit

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  crs_status #(
    .ERR_HOLD (ERR_HOLD),
    .CRC_SEC  (CRC_SEC),
    .CRC_HIGH (CRC_HIGH),
    .REF_TOUT (REF_TOUT)
  ) crs_status_i (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .bus_clk_pin          (bus_clk_pin),
    .frame_pulse_n_pin    (frame_pulse_n_pin),
    .external_status_pin  (external_status_pin),
    .maint_enable         (maint_enable),
    .evt                  (evt),
    .status_serial_output (status_serial_output),
    .status_drive_en      (status_drive_en)
  );

  crs_ctrl_model crs_ctrl_model_i (
    .bus_clk_pin          (bus_clk_pin),
    .frame_pulse_n_pin    (frame_pulse_n_pin),
    .status_serial_output (status_serial_output),
    .status_drive_en      (status_drive_en),
    .bit_idx              (bit_idx),
    .rx_bytes             (rx_bytes),
    .done_tgl             (done_tgl),
    .bad_bits             (bad_bits)
  );

  // Expected first status byte from the levels and the two toggles
  function automatic logic [7:0] status_one_of(logic [7:0] lv, logic et, logic st);
    return {lv[0], lv[1], et, st, lv[2], lv[3], lv[6], crs_pkg::UNUSED_BIT};
  endfunction

  // Ninth phase bit flips only across the slot 31 and slot 0 boundary
  function automatic logic ninth_of(logic [4:0] ps, logic [4:0] s, logic n);
    return n ^ ((ps == 5'h1F && s == 5'h00) || (ps == 5'h00 && s == 5'h1F));
  endfunction

  // Drive just after the edge so sampling never races
  task automatic tick;
    @(posedge clk_sys);
    #2;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Back-to-back pulses on one event line
  task automatic burst(input int sel, input int n);
    if (n == 0)
      return;
    tick();
    case (sel)
      0: evt.fas_err = 1'b1;
      1: evt.slip = 1'b1;
      default: evt.crc_err = 1'b1;
    endcase
    repeat (n) @(posedge clk_sys);
    #2;
    evt.fas_err = 1'b0;
    evt.slip = 1'b0;
    evt.crc_err = 1'b0;
  endtask

  // One frame: new levels and events, one phase reading, check the snapshot
  task automatic step(input int i);
    logic [7:0] lv;
    logic [7:0] b;
    logic [7:0] exp18;
    logic [7:0] exp21;
    logic [8:0] shown;
    int         k;
    int         v;
    int         nf;
    int         nc;
    lv = 8'($random(seed));
    b = 8'($random(seed));
    v = {$random(seed)} % 224;
    k = (i < 6) ? CORNER_K[i] : ((v < 168) ? v : v + 32);
    // Kept non-negative so every count below is a real count
    v = {$random(seed)} % 1024;
    nf = (i == 0) ? 32 : 8 * (v % 3);
    nc = (i == 0) ? 7 : (i == 1) ? 250 : (i >= 8) ? 1 : v % 8;
    // Lose then regain frame lock with no CRC lock, under maintenance
    if (i == 9 || i == 10)
    begin
      lv[0] = (i == 9);
      lv[5] = 1'b0;
    end
    tick();
    maint_enable = (i >= 8);
    evt.frame_lock_lost = lv[0];
    evt.multiframe_lock_lost = lv[1];
    evt.rx_all_ones_alarm = lv[2];
    evt.rx_slot16_all_ones_alarm = lv[3];
    evt.spare_bit_frame13 = lv[4];
    evt.crc_mf_lock = lv[5];
    external_status_pin = lv[6];
    evt.spare_bit_frame15 = lv[7];
    evt.nfas_byte = b;
    evt.nfas_valid = 1'b1;
    evt.rx_multiframe_pulse = 1'b1;
    tick();
    evt.nfas_valid = 1'b0;
    evt.rx_multiframe_pulse = 1'b0;
    burst(0, nf);
    burst(1, v % 4);
    burst(2, nc);
    if (fll_prev && !lv[0] && !lv[5] && maint_enable)
      ref_flag = 1'b1;
    if (lv[5] || !maint_enable)
      ref_flag = 1'b0;
    fll_prev = lv[0];
    err_acc += nf;
    // Each 16 errors give one toggle; the hold-off only delays it here
    while (err_acc >= 16)
    begin
      err_tgl = ~err_tgl;
      err_acc -= 16;
    end
    slip_tgl = slip_tgl ^ v[0];
    crc_exp = crc_exp + 8'(nc);
    // Raise the 8 kHz timing mid-bit, once the bit counter has settled
    while (bit_idx != k)
      @(bit_idx);
    #150;
    tick();
    evt.tx_8khz_timing_out = 1'b1;
    repeat (4) tick();
    evt.tx_8khz_timing_out = 1'b0;
    shown = word;
    word = {ninth_of(word[7:3], 5'(k >> 3), word[8]), 8'(k)};
    // Readings late in a frame land before the next snapshot
    if (k >= 200)
      shown = word;
    @(done_tgl);
    // A timer fall between snapshots leaves at most the one new error
    if (i == 8)
      crc_exp = rx_bytes[15:8];
    else if (maint_enable && t_prev && !rx_bytes[3])
      crc_exp = (rx_bytes[15:8] <= 8'h01) ? rx_bytes[15:8] : 8'h00;
    exp18 = status_one_of(lv, err_tgl, slip_tgl);
    exp21 = {lv[7], lv[4], 2'h0, rx_bytes[3], ref_flag, ~lv[5], shown[8]};
    check("nonalign byte", b, rx_bytes[39:32]);
    check("status one", exp18, rx_bytes[31:24]);
    check("phase byte", shown[7:0], rx_bytes[23:16]);
    check("crc count", crc_exp, rx_bytes[15:8]);
    check("status two", exp21, rx_bytes[7:0]);
    highs += int'(rx_bytes[3]);
    t_prev = rx_bytes[3];
  endtask

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: reset, sync to the stream, then sixteen frames
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    external_status_pin = 1'b0;
    maint_enable = 1'b0;
    evt = '0;
    err_count = 0;
    n_compared = 0;
    seed = 8673;
    err_acc = 0;
    highs = 0;
    err_tgl = 1'b0;
    slip_tgl = 1'b0;
    ref_flag = 1'b0;
    fll_prev = 1'b0;
    crc_exp = 8'h00;
    word = 9'h000;
    repeat (6) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    @(done_tgl);
    t_prev = rx_bytes[3];
    for (int i = 0; i < 16; i++)
    begin
      step(i);
      $display("Frame step %0d finished", i);
    end
    check("framing faults", 8'h00, (bad_bits == 0) ? 8'h00 : 8'h01);
    check("timer seen high", 8'h01, (highs > 0) ? 8'h01 : 8'h00);
    report_and_stop();
  end

  // Sixteen frames take about 2.1 ms; the margin stays under 100k cycles
  initial
  begin
    #2_450_000;
    err_count++;
    $display("Error watchdog: expected finish, seen timeout");
    report_and_stop();
  end
endmodule
